// ==== rtl/sic_pkg.sv ====
// Purpose: Constants and carriers for the logical device configuration bank
// Assumes: Indexed access, 8-bit data, one clock
// Notes:   Clock, wakeup and infrared logical devices only
//
// Behaviour
// - No bit clears on a written one; a one sets a lock bit, a zero leaves it.
// - Clock activation low blocks clock register access; contents and clock keep running.
// - Clock standard base resets 0070h; high bits 7:3 and low bit 0 read zero.
// - Clock extended base resets 0072h with the same read-only zero bits.
// - Clock interrupt number resets 8; its type resets zero, only bit 1 writable.
// - Clock and wakeup DMA selects are read-only and report no channel.
// - RAM lock bits stay set until hardware reset; bits 2:0 read zero.
// - Lock bit 7 blocks standard RAM 38h-3Fh: writes ignored, reads FFh.
// - Lock bit 6 ignores all writes to standard and extended RAM.
// - Lock bit 5 ignores writes to extended RAM bytes 00h-1Fh.
// - Lock bit 4 ignores reads of extended RAM bytes 00h-1Fh.
// - Lock bit 3 blocks all extended RAM: writes ignored, reads FFh.
// - Three index registers hold 7 bits; bit 7 reserved; relocate alarm/century.
// - Wakeup activation low blocks wakeup register access; detection keeps working.
// - Wakeup base low bits 3:0 read zero; base resets zero.
// - Wakeup interrupt number routes wakeup request; type resets 03h, bit 1 writable.
// - Infrared base resets 03E8h; high 7:3 and low 2:0 read zero.
// - Infrared DMA selects writable, reset 04h: receive then transmit.
// - Infrared config bit 7 zero ignores extended registers; one enables bank switching.
// - Infrared config bit 2 is read-only and shows transfer in progress.
// - Active with config bit 1 zero: clock stopped, outputs default, registers reachable.
// - Bit 0 set and inactive tristates outputs; transmit pin driven 0 when inactive.
// - Index 07h selects the logical device bank for later indexed accesses.
// - DMA select value 4 means no channel; 0 to 3 select that channel.
// - Global enable zero disables all devices except wakeup and clock.
package sic_pkg;
  // ------------------------------------------------------------
  // Indexes and logical device numbers
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_LDN      = 8'h07;
  localparam logic [7:0] IDX_ACT      = 8'h30;
  localparam logic [7:0] IDX_BASE_HI  = 8'h60;
  localparam logic [7:0] IDX_BASE_LO  = 8'h61;
  localparam logic [7:0] IDX_EXT_HI   = 8'h62;
  localparam logic [7:0] IDX_EXT_LO   = 8'h63;
  localparam logic [7:0] IDX_IRQ_NUM  = 8'h70;
  localparam logic [7:0] IDX_IRQ_TYPE = 8'h71;
  localparam logic [7:0] IDX_DMA0     = 8'h74;
  localparam logic [7:0] IDX_DMA1     = 8'h75;
  localparam logic [7:0] IDX_F0       = 8'hF0;
  localparam logic [7:0] IDX_F1       = 8'hF1;
  localparam logic [7:0] IDX_F2       = 8'hF2;
  localparam logic [7:0] IDX_F3       = 8'hF3;
  localparam logic [7:0] LDN_CLK      = 8'h00;
  localparam logic [7:0] LDN_WAKE     = 8'h01;
  localparam logic [7:0] LDN_IR       = 8'h02;

  // ------------------------------------------------------------
  // Reset values and masks
  // ------------------------------------------------------------
  localparam logic [7:0] RST_ZERO      = 8'h00;
  localparam logic [7:0] RST_CLK_STD_L = 8'h70;
  localparam logic [7:0] RST_CLK_EXT_L = 8'h72;
  localparam logic [7:0] RST_CLK_IRQ   = 8'h08;
  localparam logic [7:0] RST_TYPE_3    = 8'h03;
  localparam logic [7:0] RST_IR_BASE_H = 8'h03;
  localparam logic [7:0] RST_IR_BASE_L = 8'hE8;
  localparam logic [7:0] RST_IR_CFG    = 8'h02;
  localparam logic [2:0] DMA_NONE      = 3'h4;
  localparam logic [7:0] MSK_HI_11     = 8'h07;
  localparam logic [7:0] MSK_LO_A0     = 8'hFE;
  localparam logic [7:0] MSK_LO_A3     = 8'hF0;
  localparam logic [7:0] MSK_LO_A2     = 8'hF8;
  localparam logic [7:0] MSK_IRQ_NUM   = 8'h0F;
  localparam logic [7:0] MSK_TYPE_W    = 8'h02;
  localparam logic [7:0] MSK_LOCK      = 8'hF8;
  localparam logic [7:0] MSK_INDEX     = 8'h7F;
  localparam logic [7:0] MSK_IR_CFG_W  = 8'h83;
  localparam logic [7:0] BLOCKED_READ  = 8'hFF;

  // Field positions
  localparam int LCK_STD_HI   = 7;
  localparam int LCK_ALL_WR   = 6;
  localparam int LCK_EXT_WR   = 5;
  localparam int LCK_EXT_RD   = 4;
  localparam int LCK_EXT_ALL  = 3;
  localparam int CFG_BANK     = 7;
  localparam int CFG_BUSY     = 2;
  localparam int CFG_POWER    = 1;
  localparam int CFG_TRISTATE = 0;

  // RAM windows
  localparam logic [6:0] STD_LOCK_LO = 7'h38;
  localparam logic [6:0] STD_LOCK_HI = 7'h3F;
  localparam logic [6:0] EXT_LOW_TOP = 7'h1F;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] index;
    logic [7:0] wdata;
  } sic_cfg_req_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       ext;
    logic [6:0] addr;
  } sic_ram_req_s;

  typedef struct packed {
    logic       wr_ok;
    logic       rd_ok;
    logic       force_ff;
  } sic_ram_gate_s;
endpackage : sic_pkg

// ==== rtl/sic_config_bank.sv ====
// Purpose: Configuration bank for clock, wakeup and infrared logical devices
// Assumes: Index/data accesses arrive as one-cycle strobes on clk_sys
// Notes:   Read data is registered, valid the cycle after the read strobe
module sic_config_bank (
  input  wire logic                  clk_sys,
  input  wire logic                  nrst,
  input  wire sic_pkg::sic_cfg_req_s cfg_req,
  output logic [7:0]                 cfg_rdata,
  input  wire logic                  global_enable,
  input  wire sic_pkg::sic_ram_req_s ram_req,
  output sic_pkg::sic_ram_gate_s     ram_gate,
  input  wire logic                  ir_transfer_busy,
  input  wire logic                  wakeup_request,
  output logic [3:0]                 wakeup_irq_line,
  output logic                       clock_regs_enable,
  output logic                       wakeup_regs_enable,
  output logic                       ir_active,
  output logic                       ir_clock_enable,
  output logic                       ir_outputs_default,
  output logic                       ir_bank_switch_enable,
  output logic                       ir_pins_tristate,
  output logic                       ir_transmit_pin_force_low,
  output logic [15:0]                clock_std_base,
  output logic [15:0]                clock_ext_base,
  output logic [15:0]                wakeup_base,
  output logic [15:0]                ir_base,
  output logic [2:0]                 ir_receive_dma,
  output logic [2:0]                 ir_transmit_dma,
  output logic [6:0]                 date_alarm_index,
  output logic [6:0]                 month_alarm_index,
  output logic [6:0]                 century_index
);
  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic [7:0] logical_device_number_r;
  logic [7:0] clk_act_r, clk_std_h_r, clk_std_l_r, clk_ext_h_r, clk_ext_l_r;
  logic [7:0] clk_irq_r, clk_type_r, ram_lock_register_r;
  logic [7:0] date_idx_r, month_idx_r, century_idx_r;
  logic [7:0] wk_act_r, wk_base_h_r, wk_base_l_r, wk_irq_r, wk_type_r;
  logic [7:0] ir_act_r, ir_base_h_r, ir_base_l_r, ir_irq_r, ir_type_r;
  logic [7:0] ir_rx_dma_r, ir_tx_dma_r, ir_cfg_r;
  logic [7:0] rdata_nxt;
  logic       busy_s1_r, busy_s2_r;
  logic       sel_clk, sel_wk, sel_ir, wr;

  // No bit of this bank clears on a written one; activation, type and infrared config writes merge
  // Keep writable bits from data, the rest from the old value
  function automatic logic [7:0] merge(input logic [7:0] old_v,
                                       input logic [7:0] new_v,
                                       input logic [7:0] mask);
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction

  function automatic logic [7:0] dma_field(input logic [2:0] ch);
    dma_field = {5'h00, ch};
  endfunction

  assign wr      = cfg_req.wr;
  assign sel_clk = (logical_device_number_r == sic_pkg::LDN_CLK);
  assign sel_wk  = (logical_device_number_r == sic_pkg::LDN_WAKE);
  assign sel_ir  = (logical_device_number_r == sic_pkg::LDN_IR);

  // ------------------------------------------------------------
  // Device select
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      logical_device_number_r <= sic_pkg::RST_ZERO;
    end else if (wr && cfg_req.index == sic_pkg::IDX_LDN) begin
      logical_device_number_r <= cfg_req.wdata;
    end
  end

  // ------------------------------------------------------------
  // Clock logical device
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      clk_act_r           <= sic_pkg::RST_ZERO;
      clk_std_h_r         <= sic_pkg::RST_ZERO;
      clk_std_l_r         <= sic_pkg::RST_CLK_STD_L;
      clk_ext_h_r         <= sic_pkg::RST_ZERO;
      clk_ext_l_r         <= sic_pkg::RST_CLK_EXT_L;
      clk_irq_r           <= sic_pkg::RST_CLK_IRQ;
      clk_type_r          <= sic_pkg::RST_ZERO;
      ram_lock_register_r <= sic_pkg::RST_ZERO;
      date_idx_r          <= sic_pkg::RST_ZERO;
      month_idx_r         <= sic_pkg::RST_ZERO;
      century_idx_r       <= sic_pkg::RST_ZERO;
    end else if (wr && sel_clk) begin
      case (cfg_req.index)
        sic_pkg::IDX_ACT:      clk_act_r   <= merge(clk_act_r, cfg_req.wdata, 8'h01);
        sic_pkg::IDX_BASE_HI:  clk_std_h_r <= cfg_req.wdata & sic_pkg::MSK_HI_11;
        sic_pkg::IDX_BASE_LO:  clk_std_l_r <= cfg_req.wdata & sic_pkg::MSK_LO_A0;
        sic_pkg::IDX_EXT_HI:   clk_ext_h_r <= cfg_req.wdata & sic_pkg::MSK_HI_11;
        sic_pkg::IDX_EXT_LO:   clk_ext_l_r <= cfg_req.wdata & sic_pkg::MSK_LO_A0;
        sic_pkg::IDX_IRQ_NUM:  clk_irq_r   <= cfg_req.wdata & sic_pkg::MSK_IRQ_NUM;
        sic_pkg::IDX_IRQ_TYPE: clk_type_r  <= merge(clk_type_r, cfg_req.wdata,
                                                    sic_pkg::MSK_TYPE_W);
        // Sticky: only a hardware reset clears a lock bit
        sic_pkg::IDX_F0: ram_lock_register_r <= ram_lock_register_r |
                                                (cfg_req.wdata & sic_pkg::MSK_LOCK);
        sic_pkg::IDX_F1: date_idx_r    <= cfg_req.wdata & sic_pkg::MSK_INDEX;
        sic_pkg::IDX_F2: month_idx_r   <= cfg_req.wdata & sic_pkg::MSK_INDEX;
        sic_pkg::IDX_F3: century_idx_r <= cfg_req.wdata & sic_pkg::MSK_INDEX;
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Wakeup logical device
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      wk_act_r    <= sic_pkg::RST_ZERO;
      wk_base_h_r <= sic_pkg::RST_ZERO;
      wk_base_l_r <= sic_pkg::RST_ZERO;
      wk_irq_r    <= sic_pkg::RST_ZERO;
      wk_type_r   <= sic_pkg::RST_TYPE_3;
    end else if (wr && sel_wk) begin
      case (cfg_req.index)
        sic_pkg::IDX_ACT:      wk_act_r    <= merge(wk_act_r, cfg_req.wdata, 8'h01);
        sic_pkg::IDX_BASE_HI:  wk_base_h_r <= cfg_req.wdata;
        sic_pkg::IDX_BASE_LO:  wk_base_l_r <= cfg_req.wdata & sic_pkg::MSK_LO_A3;
        sic_pkg::IDX_IRQ_NUM:  wk_irq_r    <= cfg_req.wdata & sic_pkg::MSK_IRQ_NUM;
        sic_pkg::IDX_IRQ_TYPE: wk_type_r   <= merge(wk_type_r, cfg_req.wdata,
                                                    sic_pkg::MSK_TYPE_W);
        default: ; // DMA selects read-only
      endcase
    end
  end

  // ------------------------------------------------------------
  // Infrared logical device
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ir_act_r    <= sic_pkg::RST_ZERO;
      ir_base_h_r <= sic_pkg::RST_IR_BASE_H;
      ir_base_l_r <= sic_pkg::RST_IR_BASE_L;
      ir_irq_r    <= sic_pkg::RST_ZERO;
      ir_type_r   <= sic_pkg::RST_TYPE_3;
      ir_rx_dma_r <= dma_field(sic_pkg::DMA_NONE);
      ir_tx_dma_r <= dma_field(sic_pkg::DMA_NONE);
      ir_cfg_r    <= sic_pkg::RST_IR_CFG;
    end else if (wr && sel_ir) begin
      case (cfg_req.index)
        sic_pkg::IDX_ACT:      ir_act_r    <= merge(ir_act_r, cfg_req.wdata, 8'h01);
        sic_pkg::IDX_BASE_HI:  ir_base_h_r <= cfg_req.wdata & sic_pkg::MSK_HI_11;
        sic_pkg::IDX_BASE_LO:  ir_base_l_r <= cfg_req.wdata & sic_pkg::MSK_LO_A2;
        sic_pkg::IDX_IRQ_NUM:  ir_irq_r    <= cfg_req.wdata & sic_pkg::MSK_IRQ_NUM;
        sic_pkg::IDX_IRQ_TYPE: ir_type_r   <= merge(ir_type_r, cfg_req.wdata,
                                                    sic_pkg::MSK_TYPE_W);
        sic_pkg::IDX_DMA0:     ir_rx_dma_r <= dma_field(cfg_req.wdata[2:0]);
        sic_pkg::IDX_DMA1:     ir_tx_dma_r <= dma_field(cfg_req.wdata[2:0]);
        // Busy bit stays hardware-owned
        sic_pkg::IDX_F0: ir_cfg_r <= merge(ir_cfg_r, cfg_req.wdata,
                                           sic_pkg::MSK_IR_CFG_W);
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Busy input from the port's transfer logic, other domain
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      busy_s1_r <= 1'b0;
      busy_s2_r <= 1'b0;
    end else begin
      busy_s1_r <= ir_transfer_busy;
      busy_s2_r <= busy_s1_r;
    end
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  always_comb begin
    rdata_nxt = sic_pkg::RST_ZERO;
    if (cfg_req.index == sic_pkg::IDX_LDN) begin
      rdata_nxt = logical_device_number_r;
    end else if (sel_clk) begin
      case (cfg_req.index)
        sic_pkg::IDX_ACT:      rdata_nxt = clk_act_r;
        sic_pkg::IDX_BASE_HI:  rdata_nxt = clk_std_h_r;
        sic_pkg::IDX_BASE_LO:  rdata_nxt = clk_std_l_r;
        sic_pkg::IDX_EXT_HI:   rdata_nxt = clk_ext_h_r;
        sic_pkg::IDX_EXT_LO:   rdata_nxt = clk_ext_l_r;
        sic_pkg::IDX_IRQ_NUM:  rdata_nxt = clk_irq_r;
        sic_pkg::IDX_IRQ_TYPE: rdata_nxt = clk_type_r;
        sic_pkg::IDX_DMA0:     rdata_nxt = dma_field(sic_pkg::DMA_NONE);
        sic_pkg::IDX_DMA1:     rdata_nxt = dma_field(sic_pkg::DMA_NONE);
        sic_pkg::IDX_F0:       rdata_nxt = ram_lock_register_r;
        sic_pkg::IDX_F1:       rdata_nxt = date_idx_r;
        sic_pkg::IDX_F2:       rdata_nxt = month_idx_r;
        sic_pkg::IDX_F3:       rdata_nxt = century_idx_r;
        default:               rdata_nxt = sic_pkg::RST_ZERO;
      endcase
    end else if (sel_wk) begin
      case (cfg_req.index)
        sic_pkg::IDX_ACT:      rdata_nxt = wk_act_r;
        sic_pkg::IDX_BASE_HI:  rdata_nxt = wk_base_h_r;
        sic_pkg::IDX_BASE_LO:  rdata_nxt = wk_base_l_r;
        sic_pkg::IDX_IRQ_NUM:  rdata_nxt = wk_irq_r;
        sic_pkg::IDX_IRQ_TYPE: rdata_nxt = wk_type_r;
        sic_pkg::IDX_DMA0:     rdata_nxt = dma_field(sic_pkg::DMA_NONE);
        sic_pkg::IDX_DMA1:     rdata_nxt = dma_field(sic_pkg::DMA_NONE);
        default:               rdata_nxt = sic_pkg::RST_ZERO;
      endcase
    end else if (sel_ir) begin
      case (cfg_req.index)
        sic_pkg::IDX_ACT:      rdata_nxt = ir_act_r;
        sic_pkg::IDX_BASE_HI:  rdata_nxt = ir_base_h_r;
        sic_pkg::IDX_BASE_LO:  rdata_nxt = ir_base_l_r;
        sic_pkg::IDX_IRQ_NUM:  rdata_nxt = ir_irq_r;
        sic_pkg::IDX_IRQ_TYPE: rdata_nxt = ir_type_r;
        sic_pkg::IDX_DMA0:     rdata_nxt = ir_rx_dma_r;
        sic_pkg::IDX_DMA1:     rdata_nxt = ir_tx_dma_r;
        sic_pkg::IDX_F0:       rdata_nxt = {ir_cfg_r[7:3], busy_s2_r, ir_cfg_r[1:0]};
        default:               rdata_nxt = sic_pkg::RST_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cfg_rdata <= sic_pkg::RST_ZERO;
    end else if (cfg_req.rd) begin
      cfg_rdata <= rdata_nxt;
    end
  end

  // ------------------------------------------------------------
  // RAM gating for the clock's battery RAM
  // ------------------------------------------------------------
  always_comb begin
    logic std_win;
    logic ext_low;
    std_win = 1'b0;
    ext_low = 1'b0;
    std_win = !ram_req.ext && ram_req.addr >= sic_pkg::STD_LOCK_LO &&
              ram_req.addr <= sic_pkg::STD_LOCK_HI;
    ext_low = ram_req.ext && ram_req.addr <= sic_pkg::EXT_LOW_TOP;
    ram_gate.wr_ok    = ram_req.wr && clock_regs_enable;
    ram_gate.rd_ok    = ram_req.rd && clock_regs_enable;
    ram_gate.force_ff = 1'b0;
    if (ram_lock_register_r[sic_pkg::LCK_STD_HI] && std_win) begin
      ram_gate.wr_ok    = 1'b0;
      ram_gate.rd_ok    = 1'b0;
      ram_gate.force_ff = ram_req.rd;
    end
    if (ram_lock_register_r[sic_pkg::LCK_ALL_WR]) begin
      ram_gate.wr_ok = 1'b0;
    end
    if (ram_lock_register_r[sic_pkg::LCK_EXT_WR] && ext_low) begin
      ram_gate.wr_ok = 1'b0;
    end
    if (ram_lock_register_r[sic_pkg::LCK_EXT_RD] && ext_low) begin
      ram_gate.rd_ok = 1'b0;
    end
    if (ram_lock_register_r[sic_pkg::LCK_EXT_ALL] && ram_req.ext) begin
      ram_gate.wr_ok    = 1'b0;
      ram_gate.rd_ok    = 1'b0;
      ram_gate.force_ff = ram_req.rd;
    end
  end

  // ------------------------------------------------------------
  // Activation and resource outputs
  // ------------------------------------------------------------
  // Clock and wakeup ignore the global enable
  assign clock_regs_enable  = clk_act_r[0];
  assign wakeup_regs_enable = wk_act_r[0];
  assign ir_active          = ir_act_r[0] && global_enable;
  assign ir_clock_enable    = ir_active && ir_cfg_r[sic_pkg::CFG_POWER];
  assign ir_outputs_default = !ir_clock_enable;
  assign ir_bank_switch_enable = ir_cfg_r[sic_pkg::CFG_BANK];
  assign ir_pins_tristate   = !ir_active && ir_cfg_r[sic_pkg::CFG_TRISTATE];
  assign ir_transmit_pin_force_low = !ir_active;
  // Detection keeps running while inactive; routing needs a valid line
  assign wakeup_irq_line    = (wakeup_request && wk_irq_r[3:0] != 4'h0)
                              ? wk_irq_r[3:0] : 4'h0;
  assign clock_std_base     = {clk_std_h_r, clk_std_l_r};
  assign clock_ext_base     = {clk_ext_h_r, clk_ext_l_r};
  assign wakeup_base        = {wk_base_h_r, wk_base_l_r};
  assign ir_base            = {ir_base_h_r, ir_base_l_r};
  assign ir_receive_dma     = ir_rx_dma_r[2:0];
  assign ir_transmit_dma    = ir_tx_dma_r[2:0];
  assign date_alarm_index   = date_idx_r[6:0];
  assign month_alarm_index  = month_idx_r[6:0];
  assign century_index      = century_idx_r[6:0];
endmodule // sic_config_bank

// ==== sim/sic_config_bank_assertions.sv ====
// Purpose: Port-level checks for the logical device configuration bank
// Assumes: One clock, synchronous active-low reset
// Notes:   Sees only the top module's ports
module sic_config_bank_assertions (
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        global_enable,
  input wire logic        wakeup_request,
  input wire logic [3:0]  wakeup_irq_line,
  input wire logic        ir_active,
  input wire logic        ir_clock_enable,
  input wire logic        ir_outputs_default,
  input wire logic        ir_pins_tristate,
  input wire logic        ir_transmit_pin_force_low,
  input wire logic [15:0] clock_std_base,
  input wire logic [15:0] clock_ext_base,
  input wire logic [15:0] wakeup_base,
  input wire logic [15:0] ir_base
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_release; $rose(nrst); endsequence
  sequence s_base_rst;
    clock_std_base == 16'h0070 && clock_ext_base == 16'h0072 && ir_base == 16'h03E8;
  endsequence
  property p_rst; s_release |-> s_base_rst; endproperty
  property p_std; (clock_std_base & 16'hF801) == 16'h0000; endproperty
  property p_ext; (clock_ext_base & 16'hF801) == 16'h0000; endproperty
  property p_wkb; wakeup_base[3:0] == 4'h0; endproperty
  property p_irb; (ir_base & 16'hF807) == 16'h0000; endproperty
  property p_gbl; !global_enable |-> !ir_active; endproperty
  property p_clk; ir_clock_enable |-> ir_active && !ir_outputs_default; endproperty
  property p_tri; ir_pins_tristate |-> ir_transmit_pin_force_low; endproperty
  property p_txl; ir_transmit_pin_force_low == !ir_active; endproperty
  property p_irq; !wakeup_request |-> wakeup_irq_line == 4'h0; endproperty
  a_rst: assert property (p_rst)
    else $error("base registers wrong after reset");
  a_std: assert property (p_std)
    else $error("clock standard base fixed bits set");
  a_ext: assert property (p_ext)
    else $error("clock extended base fixed bits set");
  a_wkb: assert property (p_wkb)
    else $error("wakeup base not 16-byte aligned");
  a_irb: assert property (p_irb)
    else $error("infrared base fixed bits set");
  a_gbl: assert property (p_gbl)
    else $error("infrared active with global enable low");
  a_clk: assert property (p_clk)
    else $error("infrared clock enabled while inactive");
  a_tri: assert property (p_tri)
    else $error("tristate without transmit pin low");
  a_txl: assert property (p_txl)
    else $error("transmit pin force-low mismatch");
  a_irq: assert property (p_irq)
    else $error("wakeup line raised without request");
endmodule // sic_config_bank_assertions

// ==== sim/sic_config_bank_tb.sv ====
// Purpose: Self-checking bench for the logical device configuration bank
// Assumes: Inputs change on the falling edge
// Notes:   Table covers reset values and write masks per device
module sic_config_bank_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic                   clk_sys = 1'h0, nrst = 1'h0, global_enable = 1'h1;
  logic                   ir_transfer_busy = 1'h0, wakeup_request = 1'h0;
  sic_pkg::sic_cfg_req_s  cfg_req = '0;
  sic_pkg::sic_ram_req_s  ram_req = '0;
  sic_pkg::sic_ram_gate_s ram_gate;
  logic [7:0]             cfg_rdata;
  logic [3:0]             wakeup_irq_line;
  logic                   ir_active, ir_clock_enable, ir_outputs_default;
  logic                   ir_bank_switch_enable, ir_pins_tristate, ir_transmit_pin_force_low;
  logic                   clock_regs_enable, wakeup_regs_enable;
  logic [2:0]             ir_receive_dma, ir_transmit_dma;
  logic [6:0]             date_alarm_index, month_alarm_index, century_index;
  int                     n_errors = 0, total_checks = 0;
  // {ldn, index, write data, reset value, value after write}
  logic [39:0] tbl [18] = '{40'h00_60_FF_00_07, 40'h00_61_FF_70_FE, 40'h00_62_FF_00_07,
    40'h00_63_FF_72_FE, 40'h00_70_03_08_03, 40'h00_71_FF_00_02, 40'h00_74_00_04_04,
    40'h00_75_00_04_04, 40'h00_F1_FF_00_7F, 40'h00_F2_FF_00_7F, 40'h00_F3_81_00_01,
    40'h01_61_FF_00_F0, 40'h01_71_00_03_01,
    40'h01_75_00_04_04, 40'h02_60_FF_03_07, 40'h02_61_FF_E8_F8, 40'h02_74_02_04_02,
    40'h02_75_01_04_01};
  sic_config_bank DUT (.clk_sys, .nrst, .cfg_req, .cfg_rdata, .global_enable, .ram_req,
    .ram_gate, .ir_transfer_busy, .wakeup_request, .wakeup_irq_line, .clock_regs_enable,
    .wakeup_regs_enable, .ir_active, .ir_clock_enable, .ir_outputs_default,
    .ir_bank_switch_enable, .ir_pins_tristate, .ir_transmit_pin_force_low,
    .clock_std_base(), .clock_ext_base(), .wakeup_base(), .ir_base(), .ir_receive_dma,
    .ir_transmit_dma, .date_alarm_index, .month_alarm_index, .century_index);
  always #2 clk_sys = ~clk_sys;
  // ------------------------------------------------------------
  // Access and compare tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    @(negedge clk_sys);
    cfg_req = '{wr: 1'h1, rd: 1'h0, index: i, wdata: d};
    @(negedge clk_sys);
    cfg_req.wr = 1'h0;
  endtask
  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    @(negedge clk_sys);
    cfg_req = '{wr: 1'h0, rd: 1'h1, index: i, wdata: 8'h00};
    @(negedge clk_sys);
    cfg_req.rd = 1'h0;
    @(negedge clk_sys);
    chk(cfg_rdata, e);
  endtask
  task automatic ram(input logic [9:0] r);
    @(negedge clk_sys);
    ram_req = r;
    #1;
  endtask
  task automatic final_report();
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    final_report();
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
    nrst = 1'h1;
    foreach (tbl[k]) begin
      wr(8'h07, tbl[k][39:32]);
      rd(tbl[k][31:24], tbl[k][15:8]);
      wr(tbl[k][31:24], tbl[k][23:16]);
      rd(tbl[k][31:24], tbl[k][7:0]);
    end
    chk(ir_receive_dma, 3'h2);
    chk(ir_transmit_dma, 3'h1);
    chk(date_alarm_index, 7'h7F);
    chk(month_alarm_index, 7'h7F);
    chk(century_index, 7'h01);
    global_enable = 1'h0;
    wr(8'h30, 8'h01);
    chk(ir_active, 1'h0);
    chk(ir_transmit_pin_force_low, 1'h1);
    @(negedge clk_sys);
    global_enable = 1'h1;
    #1;
    chk(ir_clock_enable, 1'h1);
    wr(8'hF0, 8'h01);
    chk(ir_outputs_default, 1'h1);
    ir_transfer_busy = 1'h1;
    wr(8'hF0, 8'hFF);
    rd(8'hF0, 8'h87);
    chk(ir_bank_switch_enable, 1'h1);
    wr(8'h30, 8'h00);
    chk(ir_pins_tristate, 1'h1);
    wr(8'h07, 8'h01);
    wr(8'h70, 8'h05);
    wakeup_request = 1'h1;
    global_enable = 1'h0;
    #1;
    chk(wakeup_irq_line, 8'h05);
    chk(wakeup_regs_enable, 1'h0);
    wr(8'h30, 8'h01);
    chk(wakeup_regs_enable, 1'h1);
    global_enable = 1'h1;
    wr(8'h07, 8'h00);
    ram(10'h210);
    chk(ram_gate.wr_ok, 1'h0);
    chk(clock_regs_enable, 1'h0);
    wr(8'h30, 8'h01);
    ram(10'h210);
    chk(ram_gate.wr_ok, 1'h1);
    chk(clock_regs_enable, 1'h1);
    wr(8'hF0, 8'h10);
    ram(10'h185);
    chk(ram_gate.rd_ok, 1'h0);
    ram(10'h1A0);
    chk(ram_gate.rd_ok, 1'h1);
    wr(8'hF0, 8'h00);
    rd(8'hF0, 8'h10);
    wr(8'hF0, 8'hA7);
    rd(8'hF0, 8'hB0);
    ram(10'h138);
    chk(ram_gate.force_ff, 1'h1);
    ram(10'h137);
    chk(ram_gate.force_ff, 1'h0);
    ram(10'h29F);
    chk(ram_gate.wr_ok, 1'h0);
    ram(10'h2A0);
    chk(ram_gate.wr_ok, 1'h1);
    wr(8'hF0, 8'h48);
    ram(10'h1C0);
    chk(ram_gate.force_ff, 1'h1);
    ram(10'h210);
    chk(ram_gate.wr_ok, 1'h0);
    // Mid-run hardware reset is the only way out of the lock
    @(negedge clk_sys);
    nrst = 1'h0;
    repeat (2) @(negedge clk_sys);
    nrst = 1'h1;
    rd(8'hF0, 8'h00);
    chk(clock_regs_enable, 1'h0);
    final_report();
  end
endmodule // sic_config_bank_tb
bind sic_config_bank sic_config_bank_assertions u_chk (.clk_sys(clk_sys), .nrst(nrst),
  .global_enable(global_enable), .wakeup_request(wakeup_request),
  .wakeup_irq_line(wakeup_irq_line), .ir_active(ir_active),
  .ir_clock_enable(ir_clock_enable), .ir_outputs_default(ir_outputs_default),
  .ir_pins_tristate(ir_pins_tristate), .ir_transmit_pin_force_low(ir_transmit_pin_force_low),
  .clock_std_base(clock_std_base), .clock_ext_base(clock_ext_base),
  .wakeup_base(wakeup_base), .ir_base(ir_base));
